// File: rtl/qpb_ports.v
`timescale 1ns/1ps
`default_nettype none
`include "qpb_regs.vh"
// Function
// - port zero open-drain, floats where latch one
// - port zero multiplexes low address then data
// - port zero bus ones driven strongly
// - ports one to three quasi-bidirectional, weak pull
// - port two drives high address byte
// - port two address ones use strong pull
// - short pointer access keeps port two latch
// - port one bits 0-2 timer/array pins
// - port one bits 3-7 capture/compare pins
// - port three bits serial, irq, timer, strobes
// - programming: code byte in, verify out
// - ports four, five quasi-bidirectional
module qpb_ports #(
  parameter WIDTH = 8
) (
  input  wire             clk,
  input  wire             reset,
  // core side: latch writes, one strobe per port
  input  wire [5:0]       latch_wr,
  input  wire [WIDTH-1:0] latch_data,
  // external bus control from the core
  input  wire             bus_addr_phase,
  input  wire             bus_data_out,
  input  wire             bus_data_in,
  input  wire             bus_wide_ptr,
  input  wire [15:0]      bus_addr,
  input  wire [WIDTH-1:0] bus_wdata,
  // programming mode
  input  wire             prog_mode,
  input  wire             verify_mode,
  input  wire [WIDTH-1:0] verify_byte,
  // alternate outputs from peripherals (idle high)
  input  wire             timer_two_clk_out,
  input  wire [4:0]       cmp_out,
  input  wire             serial_tx,
  input  wire             write_strobe_n,
  input  wire             read_strobe_n,
  // pins
  input  wire [WIDTH-1:0] port_zero_in,
  input  wire [WIDTH-1:0] port_one_in,
  input  wire [WIDTH-1:0] port_two_in,
  input  wire [WIDTH-1:0] port_three_in,
  input  wire [WIDTH-1:0] port_four_in,
  input  wire [WIDTH-1:0] port_five_in,
  output reg  [WIDTH-1:0] port_zero_out,
  output reg  [WIDTH-1:0] port_zero_oe_n,
  output reg  [WIDTH-1:0] port_two_out,
  output reg  [WIDTH-1:0] port_two_strong_n,
  output wire [WIDTH-1:0] port_one_out,
  output wire [WIDTH-1:0] port_one_weak_n,
  output wire [WIDTH-1:0] port_two_weak_n,
  output wire [WIDTH-1:0] port_three_out,
  output wire [WIDTH-1:0] port_three_weak_n,
  output wire [WIDTH-1:0] port_four_out,
  output wire [WIDTH-1:0] port_four_weak_n,
  output wire [WIDTH-1:0] port_five_out,
  output wire [WIDTH-1:0] port_five_weak_n,
  // sampled pin levels back to the core
  output reg  [WIDTH-1:0] port_zero_value,
  output wire [WIDTH-1:0] port_one_value,
  output wire [WIDTH-1:0] port_two_value,
  output wire [WIDTH-1:0] port_three_value,
  output wire [WIDTH-1:0] port_four_value,
  output wire [WIDTH-1:0] port_five_value,
  // alternate inputs to peripherals
  output reg              timer_two_count_pin,
  output reg              timer_two_ext_ctrl_pin,
  output reg              array_ext_clock_pin,
  output reg  [4:0]       module_cmp_io_pin,
  output reg              serial_rx,
  output reg              ext_irq_zero_pin,
  output reg              ext_irq_one_pin,
  output reg              timer_zero_in_pin,
  output reg              timer_one_in_pin,
  // programming address and code byte
  output reg  [15:0]      prog_addr,
  output reg  [WIDTH-1:0] prog_byte
);
  // ------------------------------------------------------------
  // latches and alternate output merge
  // ------------------------------------------------------------
  reg  [WIDTH-1:0] latch_zero;     // port zero latch
  wire [WIDTH-1:0] two_weak_out;   // quasi drive from port two module
  wire [WIDTH-1:0] alt_one;        // port one alternate outputs
  wire [WIDTH-1:0] alt_three;      // port three alternate outputs
  wire [WIDTH-1:0] ones;           // no alternate use
  wire             bus_active;     // external bus cycle under way

  assign ones       = {WIDTH{1'b1}};
  assign bus_active = bus_addr_phase | bus_data_out | bus_data_in;
  // second timer clock out on bit 0, compare outputs on bits 3..7
  assign alt_one = {cmp_out, 2'b11, timer_two_clk_out};
  // serial out on bit 1, strobes on bits 6 and 7
  assign alt_three = {read_strobe_n, write_strobe_n, 4'hF, serial_tx, 1'b1};

  // port zero latch kept here since it is open-drain
  always @(posedge clk) begin
    if (reset) begin
      latch_zero <= `QPB_LATCH_RST;
    end else if (latch_wr[0]) begin
      latch_zero <= latch_data;
    end
  end

  // ------------------------------------------------------------
  // port zero drive
  // ------------------------------------------------------------
  // bus ones are driven actively; plain port ones float. during a read
  // data phase the bus is released so memory can drive it.
  always @(posedge clk) begin
    if (reset) begin
      port_zero_out   <= `QPB_LATCH_RST;
      port_zero_oe_n  <= `QPB_LATCH_RST;
      port_zero_value <= `QPB_LATCH_RST;
    end else begin
      port_zero_value <= port_zero_in;
      if (verify_mode) begin
        port_zero_out  <= verify_byte;
        port_zero_oe_n <= verify_byte;           // ones float, ext pull-ups
      end else if (prog_mode) begin
        port_zero_out  <= `QPB_LATCH_RST;        // programmer drives
        port_zero_oe_n <= `QPB_LATCH_RST;
      end else if (bus_addr_phase) begin
        port_zero_out  <= bus_addr[7:0];
        port_zero_oe_n <= `QPB_BYTE_ZERO;
      end else if (bus_data_out) begin
        port_zero_out  <= bus_wdata;
        port_zero_oe_n <= `QPB_BYTE_ZERO;
      end else if (bus_data_in) begin
        port_zero_out  <= `QPB_LATCH_RST;
        port_zero_oe_n <= `QPB_LATCH_RST;
      end else begin
        port_zero_out  <= latch_zero;
        port_zero_oe_n <= latch_zero;            // ones float, zeros pulled low
      end
    end
  end

  // ------------------------------------------------------------
  // port two address override with strong drive
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      port_two_out      <= `QPB_LATCH_RST;
      port_two_strong_n <= `QPB_LATCH_RST;
    end else if (bus_active && bus_wide_ptr && !prog_mode) begin
      port_two_out      <= bus_addr[15:8];
      port_two_strong_n <= `QPB_BYTE_ZERO;
    end else begin
      port_two_out      <= two_weak_out;         // latch contents
      port_two_strong_n <= `QPB_LATCH_RST;
    end
  end

  // ------------------------------------------------------------
  // quasi ports
  // ------------------------------------------------------------
  qpb_qport #(.WIDTH(WIDTH)) u_one (
    .clk(clk), .reset(reset), .wr_en(latch_wr[1]), .wr_data(latch_data),
    .alt_out(alt_one), .pin_in(port_one_in), .latch(),
    .pin_out(port_one_out), .pull_weak_n(port_one_weak_n),
    .pin_value(port_one_value));
  qpb_qport #(.WIDTH(WIDTH)) u_two (
    .clk(clk), .reset(reset), .wr_en(latch_wr[2]), .wr_data(latch_data),
    .alt_out(ones), .pin_in(port_two_in), .latch(),
    .pin_out(two_weak_out), .pull_weak_n(port_two_weak_n),
    .pin_value(port_two_value));
  qpb_qport #(.WIDTH(WIDTH)) u_three (
    .clk(clk), .reset(reset), .wr_en(latch_wr[3]), .wr_data(latch_data),
    .alt_out(alt_three), .pin_in(port_three_in), .latch(),
    .pin_out(port_three_out), .pull_weak_n(port_three_weak_n),
    .pin_value(port_three_value));
  qpb_qport #(.WIDTH(WIDTH)) u_four (
    .clk(clk), .reset(reset), .wr_en(latch_wr[4]), .wr_data(latch_data),
    .alt_out(ones), .pin_in(port_four_in), .latch(),
    .pin_out(port_four_out), .pull_weak_n(port_four_weak_n),
    .pin_value(port_four_value));
  qpb_qport #(.WIDTH(WIDTH)) u_five (
    .clk(clk), .reset(reset), .wr_en(latch_wr[5]), .wr_data(latch_data),
    .alt_out(ones), .pin_in(port_five_in), .latch(),
    .pin_out(port_five_out), .pull_weak_n(port_five_weak_n),
    .pin_value(port_five_value));

  // ------------------------------------------------------------
  // alternate inputs and programming capture
  // ------------------------------------------------------------
  // pins registered once; the core treats them as synchronous
  always @(posedge clk) begin
    if (reset) begin
      timer_two_count_pin    <= 1'b1;
      timer_two_ext_ctrl_pin <= 1'b1;
      array_ext_clock_pin    <= 1'b1;
      module_cmp_io_pin      <= 5'h1F;
      serial_rx              <= 1'b1;
      ext_irq_zero_pin       <= 1'b1;
      ext_irq_one_pin        <= 1'b1;
      timer_zero_in_pin      <= 1'b1;
      timer_one_in_pin       <= 1'b1;
      prog_addr              <= 16'h0000;
      prog_byte              <= `QPB_BYTE_ZERO;
    end else begin
      timer_two_count_pin    <= port_one_in[`QPB_ONE_COUNT_BIT];
      timer_two_ext_ctrl_pin <= port_one_in[`QPB_ONE_CTRL_BIT];
      array_ext_clock_pin    <= port_one_in[`QPB_ONE_ACLK_BIT];
      module_cmp_io_pin      <= port_one_in[WIDTH-1:`QPB_ONE_CMP_LO_BIT];
      serial_rx              <= port_three_in[`QPB_THREE_RX_BIT];
      ext_irq_zero_pin       <= port_three_in[`QPB_THREE_IRQA_BIT];
      ext_irq_one_pin        <= port_three_in[`QPB_THREE_IRQB_BIT];
      timer_zero_in_pin      <= port_three_in[`QPB_THREE_TMRA_BIT];
      timer_one_in_pin       <= port_three_in[`QPB_THREE_TMRB_BIT];
      if (prog_mode || verify_mode) begin
        // address pieces come from the programmer
        prog_addr <= {port_three_in[`QPB_THREE_TMRB_BIT:`QPB_THREE_TMRA_BIT],
                      port_two_in[`QPB_PROG_HI_BITS-1:0], port_one_in};
        prog_byte <= port_zero_in;
      end
    end
  end
endmodule
`default_nettype wire

// File: rtl/qpb_regs.vh
`ifndef QPB_REGS_VH
`define QPB_REGS_VH
// ------------------------------------------------------------
// port latch reset value and bit positions of alternate pins
// ------------------------------------------------------------
`define QPB_LATCH_RST      8'hFF
`define QPB_BYTE_ZERO      8'h00
`define QPB_ONE_COUNT_BIT  0
`define QPB_ONE_CTRL_BIT   1
`define QPB_ONE_ACLK_BIT   2
`define QPB_ONE_CMP_LO_BIT 3
`define QPB_THREE_RX_BIT   0
`define QPB_THREE_TX_BIT   1
`define QPB_THREE_IRQA_BIT 2
`define QPB_THREE_IRQB_BIT 3
`define QPB_THREE_TMRA_BIT 4
`define QPB_THREE_TMRB_BIT 5
`define QPB_THREE_WSTB_BIT 6
`define QPB_THREE_RSTB_BIT 7
`define QPB_PROG_HI_BITS   6
`endif

// File: rtl/qpb_qport.v
`timescale 1ns/1ps
`default_nettype none
`include "qpb_regs.vh"
// ------------------------------------------------------------
// one quasi-bidirectional port: latch, drive and pin sample
// ------------------------------------------------------------
module qpb_qport #(
  parameter WIDTH = 8
) (
  input  wire             clk,
  input  wire             reset,
  input  wire             wr_en,
  input  wire [WIDTH-1:0] wr_data,
  input  wire [WIDTH-1:0] alt_out,
  input  wire [WIDTH-1:0] pin_in,
  output reg  [WIDTH-1:0] latch,
  output reg  [WIDTH-1:0] pin_out,
  output reg  [WIDTH-1:0] pull_weak_n,
  output reg  [WIDTH-1:0] pin_value
);
  // latch, then and with alternate output; a one leaves only the weak
  // pull-up on, so the pin reads as input (weak_n low = weak pull on)
  always @(posedge clk) begin
    if (reset) begin
      latch       <= `QPB_LATCH_RST;
      pin_out     <= `QPB_LATCH_RST;
      pull_weak_n <= {WIDTH{1'b0}};
      pin_value   <= `QPB_LATCH_RST;
    end else begin
      if (wr_en) begin
        latch <= wr_data;
      end
      pin_out     <= latch & alt_out;
      pull_weak_n <= ~(latch & alt_out);
      pin_value   <= pin_in;
    end
  end
endmodule
`default_nettype wire

// File: testbench/qpb_ports_chk.sv
`timescale 1ns/1ps
`default_nettype none
// -------------------------
// port block checker
// -------------------------
module qpb_ports_chk (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        bus_addr_phase,
  input wire logic        bus_data_out,
  input wire logic        bus_wide_ptr,
  input wire logic        prog_mode,
  input wire logic        verify_mode,
  input wire logic        timer_two_count_pin,
  input wire logic        timer_two_ext_ctrl_pin,
  input wire logic        serial_rx,
  input wire logic        array_ext_clock_pin,
  input wire logic        ext_irq_zero_pin,
  input wire logic        ext_irq_one_pin,
  input wire logic        timer_zero_in_pin,
  input wire logic        timer_one_in_pin,
  input wire logic [4:0]  module_cmp_io_pin,
  input wire logic [5:0]  latch_wr,
  input wire logic [15:0] prog_addr,
  input wire logic [15:0] bus_addr,
  input wire logic [7:0]  latch_data,
  input wire logic [7:0]  bus_wdata,
  input wire logic [7:0]  verify_byte,
  input wire logic [7:0]  port_zero_in,
  input wire logic [7:0]  port_one_in,
  input wire logic [7:0]  port_two_in,
  input wire logic [7:0]  port_three_in,
  input wire logic [7:0]  port_zero_out,
  input wire logic [7:0]  port_zero_oe_n,
  input wire logic [7:0]  port_two_out,
  input wire logic [7:0]  port_two_strong_n,
  input wire logic [7:0]  port_one_weak_n,
  input wire logic [7:0]  port_four_out,
  input wire logic [7:0]  port_four_weak_n,
  input wire logic [7:0]  prog_byte
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // address phase not overridden by the programming modes
  sequence s_addr; bus_addr_phase && !prog_mode && !verify_mode; endsequence
  // two cycles with no address phase and no write data phase on port zero
  sequence s_idle; (!bus_addr_phase && !bus_data_out) [*2]; endsequence
  property p_rst; $fell(reset) |-> port_zero_oe_n == 8'hFF && port_one_weak_n == 8'h00
    && port_two_strong_n == 8'hFF && prog_addr == 16'h0000;
  endproperty
  a_rst: assert property (p_rst) else $error("not idle after reset");
  property p_od; s_idle |-> (port_zero_out & ~port_zero_oe_n) == 8'h00;
  endproperty
  a_od: assert property (p_od) else $error("port zero drives a one");
  property p_addr_lo; s_addr |=> port_zero_out == $past(bus_addr[7:0]) && port_zero_oe_n == 8'h00;
  endproperty
  a_addr_lo: assert property (p_addr_lo) else $error("low address wrong");
  property p_addr_hi; s_addr ##0 bus_wide_ptr |=> port_two_out == $past(bus_addr[15:8])
    && port_two_strong_n == 8'h00;
  endproperty
  a_addr_hi: assert property (p_addr_hi) else $error("high address wrong");
  property p_short; s_addr ##0 !bus_wide_ptr |=> port_two_strong_n == 8'hFF;
  endproperty
  a_short: assert property (p_short) else $error("port two strong on short access");
  property p_wdata; bus_data_out && !bus_addr_phase && !prog_mode && !verify_mode
    |=> port_zero_out == $past(bus_wdata) && port_zero_oe_n == 8'h00;
  endproperty
  a_wdata: assert property (p_wdata) else $error("write data wrong");
  property p_verify; verify_mode |=> port_zero_oe_n == $past(verify_byte)
    && (port_zero_out & ~port_zero_oe_n) == 8'h00;
  endproperty
  a_verify: assert property (p_verify) else $error("verify byte wrong");
  property p_prog; prog_mode && !verify_mode |=> prog_byte == $past(port_zero_in)
    && prog_addr == $past({port_three_in[5:4], port_two_in[5:0], port_one_in});
  endproperty
  a_prog: assert property (p_prog) else $error("programming capture wrong");
  property p_quasi; latch_wr[4] |-> ##2 port_four_out == $past(latch_data, 2)
    && port_four_weak_n == ~port_four_out;
  endproperty
  a_quasi: assert property (p_quasi) else $error("port four latch path wrong");
  property p_alt; !$past(reset) |-> {module_cmp_io_pin, array_ext_clock_pin,
    timer_two_ext_ctrl_pin, timer_two_count_pin} == $past(port_one_in) && {timer_one_in_pin,
    timer_zero_in_pin, ext_irq_one_pin, ext_irq_zero_pin, serial_rx}
    == {$past(port_three_in[5:2]), $past(port_three_in[0])};
  endproperty
  a_alt: assert property (p_alt) else $error("alternate input wrong");
endmodule
bind qpb_ports qpb_ports_chk u_chk (.*);
`default_nettype wire

// File: testbench/qpb_board.sv
`timescale 1ns/1ps
`default_nettype none
// -------------------------
// board, memories and programmer
// -------------------------
module qpb_board (
  input  wire logic [7:0]  port_zero_out, port_zero_oe_n, port_one_out, port_two_out,
  input  wire logic [7:0]  port_three_out, port_four_out, port_five_out,
  input  wire logic [47:0] pull_low,
  output wire logic [7:0]  port_zero_in, port_one_in, port_two_in,
  output wire logic [7:0]  port_three_in, port_four_in, port_five_in
);
  // every line has a board pull-up and outside parties only pull low,
  // so a contested line settles low as wired logic would
  assign port_zero_in = (port_zero_oe_n | port_zero_out) & ~pull_low[7:0];
  // a latched one is only a weak pull, so the board can override it
  assign port_one_in = port_one_out & ~pull_low[15:8];
  assign port_two_in = port_two_out & ~pull_low[23:16];
  assign port_three_in = port_three_out & ~pull_low[31:24];
  assign port_four_in = port_four_out & ~pull_low[39:32];
  assign port_five_in = port_five_out & ~pull_low[47:40];
endmodule
`default_nettype wire

// File: testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// -------------------------
// port block bench
// -------------------------
module tb_top;
  // one latch write: port, byte, board pull-down mask
  typedef struct packed {logic [2:0] port; logic [7:0] data; logic [7:0] pull;} qpb_row_t;
  localparam qpb_row_t rows [7] = '{'{3'h0, 8'h0F, 8'h00}, '{3'h0, 8'hFF, 8'h3C},
    '{3'h1, 8'h0F, 8'h00}, '{3'h2, 8'hA5, 8'h00}, '{3'h3, 8'hF0, 8'h30},
    '{3'h4, 8'h3C, 8'h00}, '{3'h5, 8'hFF, 8'h81}};
  logic clk, reset, bus_addr_phase, bus_data_out, bus_data_in, bus_wide_ptr, prog_mode;
  logic verify_mode, timer_two_clk_out, serial_tx, write_strobe_n, read_strobe_n;
  logic timer_two_count_pin, timer_two_ext_ctrl_pin, array_ext_clock_pin, serial_rx;
  logic ext_irq_zero_pin, ext_irq_one_pin, timer_zero_in_pin, timer_one_in_pin;
  logic [4:0]  cmp_out, module_cmp_io_pin;
  logic [5:0]  latch_wr;
  logic [15:0] prog_addr;
  logic [15:0] bus_addr;
  logic [47:0] pull_low;
  logic [7:0]  latch_data, bus_wdata, verify_byte, prog_byte, port_zero_out, port_zero_oe_n;
  logic [7:0]  port_two_out, port_two_strong_n, port_one_out, port_one_weak_n, port_two_weak_n;
  logic [7:0]  port_three_out, port_three_weak_n, port_four_out, port_four_weak_n;
  logic [7:0]  port_five_out, port_five_weak_n, port_zero_in, port_one_in, port_two_in;
  logic [7:0]  port_three_in, port_four_in, port_five_in, port_zero_value, port_one_value;
  logic [7:0]  port_two_value, port_three_value, port_four_value, port_five_value;
  // sampled pin levels, port k at bits 8k+7:8k like the pull mask
  wire  [47:0] vals = {port_five_value, port_four_value, port_three_value, port_two_value,
                       port_one_value, port_zero_value};
  int fails = 0;
  int comparisons = 0;
  qpb_ports dut (.*);
  qpb_board board (.*);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    if (fails == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // hang guard, far beyond the main sequence
  initial begin
    repeat (2000) @(posedge clk);
    fails++;
    finish_test;
  end
  initial begin
    // peripherals idle high, all bus and programming modes off
    {reset, timer_two_clk_out, serial_tx, write_strobe_n, read_strobe_n, cmp_out} = 10'h3FF;
    {bus_addr_phase, bus_data_out, bus_data_in, bus_wide_ptr, prog_mode, verify_mode,
     latch_wr, latch_data, bus_addr, bus_wdata, verify_byte, pull_low} = '0;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    chk(port_zero_oe_n, 8'hFF);
    // table: write a latch, let the board pull, read the pin back
    for (int i = 0; i < 7; i++) begin
      @(posedge clk);
      latch_wr <= 6'h01 << rows[i].port;
      latch_data <= rows[i].data;
      pull_low <= 48'(rows[i].pull) << (rows[i].port * 8);
      @(posedge clk);
      latch_wr <= 6'h00;
      repeat (3) @(posedge clk);
      #1;
      chk(vals[rows[i].port * 8 +: 8], rows[i].data & ~rows[i].pull);
    end
    // weak pull-ups sit only where the latch holds a one
    chk(port_two_weak_n, 8'h5A);
    chk(port_three_weak_n, 8'h0F);
    chk(port_five_weak_n, 8'h00);
    // peripheral outputs gate the latched ones on ports one and three
    @(posedge clk);
    {timer_two_clk_out, serial_tx, write_strobe_n, read_strobe_n, cmp_out} <= 9'h02A;
    repeat (2) @(posedge clk);
    #1;
    chk(port_one_out, 8'h06);
    chk(port_three_out, 8'hB0);
    // address phase straight into a write data phase
    @(posedge clk);
    {timer_two_clk_out, serial_tx, write_strobe_n, read_strobe_n, cmp_out} <= 9'h1FF;
    pull_low <= 48'h0;
    {bus_addr_phase, bus_wide_ptr, bus_addr} <= {2'b11, 16'h1234};
    @(posedge clk);
    {bus_addr_phase, bus_data_out, bus_wdata} <= {2'b01, 8'hA5};
    #1;
    chk(port_zero_out, 8'h34);
    chk(port_two_out, 8'h12);
    chk(port_zero_oe_n | port_two_strong_n, 8'h00);
    @(posedge clk);
    {bus_addr_phase, bus_data_out, bus_wide_ptr} <= 3'b100;
    #1;
    chk(port_zero_out, 8'hA5);
    @(posedge clk);
    bus_addr_phase <= 1'b0;
    @(posedge clk);
    #1;
    chk(port_two_value, 8'hA5);
    // reset again mid-run: latches must return to ones
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    chk(port_four_out, 8'hFF);
    // programmer presents code byte and address by pulling lines low
    @(posedge clk);
    prog_mode <= 1'b1;
    pull_low <= 48'h0000_0015_CB3C;
    repeat (3) @(posedge clk);
    #1;
    chk(prog_byte, 8'hC3);
    chk(prog_addr[7:0], 8'h34);
    chk(prog_addr[15:8], 8'hEA);
    // verify wins over a bus phase and a read phase at the same time
    @(posedge clk);
    {prog_mode, verify_mode, bus_addr_phase, bus_data_in} <= 4'b0111;
    verify_byte <= 8'h96;
    pull_low <= 48'h0;
    repeat (3) @(posedge clk);
    #1;
    chk(port_zero_oe_n, 8'h96);
    chk(port_zero_value, 8'h96);
    finish_test;
  end
endmodule
`default_nettype wire
